// ---- rtl/spts_defs.vh ----
// Purpose: Constants for the shutdown path test sequencer.
// Assumes: 20 MHz mclk, Avalon-MM register slave with 32-bit data.
// Notes:   Register offsets are word addresses, one per 32-bit register.
`ifndef SPTS_DEFS_VH
`define SPTS_DEFS_VH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define SPTS_REG_CTRL      4'h0
`define SPTS_REG_CFG       4'h1
`define SPTS_REG_CHECK     4'h2
`define SPTS_REG_MODESW    4'h3
`define SPTS_REG_STATUS    4'h4
`define SPTS_REG_IRQ_STAT  4'h5
`define SPTS_REG_IRQ_MASK  4'h6
`define SPTS_REG_ALARM     4'h7

// ---------------------------------------------------------------
// Control fields (CTRL register)
// ---------------------------------------------------------------
`define SPTS_CTRL_DRV_SEL  0
`define SPTS_CTRL_KER_SEL  1
`define SPTS_CTRL_EXT_SEL  2

// ---------------------------------------------------------------
// Configuration fields (CFG register)
// ---------------------------------------------------------------
`define SPTS_CFG_INTERNAL  0
`define SPTS_CFG_STATUS_IO 1

// ---------------------------------------------------------------
// Interrupt / event bits
// ---------------------------------------------------------------
`define SPTS_EV_DRV_FAIL   0
`define SPTS_EV_KER_FAIL   1
`define SPTS_EV_EXT_FAIL   2
`define SPTS_EV_MODESW     3
`define SPTS_EV_STOPF      4
`define SPTS_EV_PASS       5
`define SPTS_EV_W          6

// ---------------------------------------------------------------
// Alarm codes, reset values and tick divider count
// ---------------------------------------------------------------
`define SPTS_INFO_EXT_STOP 16'h003A
`define SPTS_INFO_NO_CHECK 16'h03F2
`define SPTS_CHECK_RST     24'h0186A0
`define SPTS_MODESW_RST    24'h0186A0
`define SPTS_TICK_DIV      8'h13

`endif

// ---- rtl/spts_timer.v ----
// Purpose: Checkback down-counter that counts enable ticks.
// Assumes: tick is a one-cycle enable pulse from the main divider.
// Notes:   Expired stays high until the next load.
`timescale 1ns/1ps
module spts_timer #(
  parameter W = 24
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         load,
  input  wire [W-1:0] value,
  input  wire         run,
  input  wire         tick,
  output reg          expired
);
  reg [W-1:0] count;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // A zero load value expires on the first tick, so no test runs unbounded.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= {W{1'b0}};
      expired <= 1'b0;
    end else if (load) begin
      count   <= value;
      expired <= 1'b0;
    end else if (run && tick && !expired) begin
      if (count <= {{(W-1){1'b0}}, 1'b1})
        expired <= 1'b1;
      else
        count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // spts_timer

// ---- rtl/spts_sequencer.v ----
// Purpose: Forced check of the pulse shutdown paths, drive, kernel and external channel.
// Assumes: Avalon-MM slave on mclk; pin inputs are asynchronous.
// Notes:   Timer values count 1 us ticks; a failed drive, kernel or external test latches.
`timescale 1ns/1ps
module spts_sequencer #(
  parameter AXES = 6
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire [3:0]       avs_address,
  input  wire             avs_read,
  input  wire             avs_write,
  input  wire [31:0]      avs_writedata,
  output reg  [31:0]      avs_readdata,
  output wire             avs_waitrequest,
  input  wire             drv_test_select,
  input  wire             ker_test_select,
  input  wire             ext_test_select,
  input  wire [AXES-1:0]  axis_map,
  input  wire             status_io_in,
  input  wire             status_if_in,
  input  wire             ext_stop_present,
  input  wire [3:0]       monitor_state_in,
  output reg              drv_pulse_cancel,
  output reg              drv_pulses_cancelled,
  output reg              int_pulse_cancel,
  output reg              ext_pulse_enable,
  output reg              test_in_progress,
  output reg  [AXES-1:0]  ext_test_running,
  output reg              immediate_stop,
  output reg              stop_f,
  output reg  [3:0]       monitor_state,
  output wire             irq
);
`include "spts_defs.vh"

  localparam S_IDLE = 6'h01;
  localparam S_DRV  = 6'h02;
  localparam S_KER  = 6'h04;
  localparam S_EXT  = 6'h08;
  localparam S_DONE = 6'h10;
  localparam S_LOCK = 6'h20;

  // ---------------------------------------------------------------
  // Reset release and input synchronisers
  // ---------------------------------------------------------------
  reg        rst_m;
  reg        rst_s;
  wire       rst_sn = rst_s;

  // Asynchronous assert, synchronous release of the internal reset.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  reg [5:0] pin_m;
  reg [5:0] pin_s;
  // Pin inputs pass two flops; only the second one is read by logic.
  always @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      pin_m <= 6'h00;
      pin_s <= 6'h00;
    end else begin
      pin_m <= {ext_stop_present, status_if_in, status_io_in,
                ext_test_select, ker_test_select, drv_test_select};
      pin_s <= pin_m;
    end
  end
  wire drv_sel  = pin_s[0];
  wire ker_sel  = pin_s[1];
  wire ext_sel  = pin_s[2];
  wire ext_stop = pin_s[5];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [2:0]  ctrl;
  reg [1:0]  cfg;
  reg [23:0] check_time;
  reg [23:0] modesw_time;
  reg [6:0]  irq_stat;
  reg [6:0]  irq_mask;
  reg [15:0] alarm_info;
  reg [5:0]  state;
  reg [2:0]  mode;
  reg [6:0]  ev;

  // Pulse status source: assignment zero means the drive interface.
  wire pulses_off = cfg[`SPTS_CFG_STATUS_IO] ? pin_s[3] : pin_s[4];

  // Selections come from pins or from software control bits.
  wire sel_drv = drv_sel | ctrl[`SPTS_CTRL_DRV_SEL];
  wire sel_ker = ker_sel | ctrl[`SPTS_CTRL_KER_SEL];
  wire sel_ext = ext_sel | ctrl[`SPTS_CTRL_EXT_SEL];
  wire any_sel = sel_drv | sel_ker | sel_ext;

  wire wr = avs_write & ~avs_waitrequest;
  // One wait state on reads lets read data come from a flop and still stand at the completing edge.
  reg        rd_done;
  assign avs_waitrequest = avs_read & ~rd_done;
  assign irq = |(irq_stat & irq_mask);

  // ---------------------------------------------------------------
  // Tick divider and timers
  // ---------------------------------------------------------------
  reg [7:0] div;
  wire      tick = (div == `SPTS_TICK_DIV);
  // One tick per microsecond keeps the timer widths small.
  always @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn)
      div <= 8'h00;
    else if (tick)
      div <= 8'h00;
    else
      div <= div + 8'h01;
  end

  wire start = (state == S_IDLE) & any_sel & ~pulses_off;
  wire chk_exp;
  wire msw_exp;

  spts_timer #(.W(24)) u_check (
    .clk     (mclk),
    .rst_n   (rst_sn),
    .load    (start),
    .value   (check_time),
    .run     ((state == S_DRV) | (state == S_KER) | (state == S_EXT)),
    .tick    (tick),
    .expired (chk_exp)
  );

  // Mode-switch timer runs only while an external stop meets the external test.
  spts_timer #(.W(24)) u_modesw (
    .clk     (mclk),
    .rst_n   (rst_sn),
    .load    (~(sel_ext & ext_stop)),
    .value   (modesw_time),
    .run     (1'b1),
    .tick    (tick),
    .expired (msw_exp)
  );

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  reg msw_seen;
  always @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      state            <= S_IDLE;
      mode             <= 3'h0;
      ev               <= 7'h00;
      drv_pulse_cancel <= 1'b0;
      int_pulse_cancel <= 1'b0;
      ext_pulse_enable <= 1'b1;
      test_in_progress <= 1'b0;
      ext_test_running <= {AXES{1'b0}};
      immediate_stop   <= 1'b0;
      stop_f           <= 1'b0;
      alarm_info       <= 16'h0000;
      msw_seen         <= 1'b0;
    end else begin
      ev <= 7'h00;
      // Alarm 58 fires once per stretch of external stop during selection.
      if (msw_exp && !msw_seen) begin
        msw_seen                 <= 1'b1;
        alarm_info               <= `SPTS_INFO_EXT_STOP;
        ev[`SPTS_EV_MODESW]      <= 1'b1;
      end else if (!(sel_ext && ext_stop)) begin
        msw_seen <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (any_sel && pulses_off) begin
            stop_f             <= 1'b1;
            ev[`SPTS_EV_STOPF] <= 1'b1;
            state              <= S_DONE;
          end else if (sel_ext) begin
            mode             <= 3'h4;
            ext_pulse_enable <= 1'b0;
            test_in_progress <= 1'b1;
            ext_test_running <= axis_map;
            state            <= S_EXT;
          end else if (sel_ker) begin
            mode             <= 3'h2;
            test_in_progress <= 1'b1;
            if (cfg[`SPTS_CFG_INTERNAL])
              int_pulse_cancel <= 1'b1;
            else
              ext_pulse_enable <= 1'b0;
            state            <= S_KER;
          end else if (sel_drv) begin
            mode             <= 3'h1;
            drv_pulse_cancel <= 1'b1;
            test_in_progress <= 1'b1;
            state            <= S_DRV;
          end
        end
        S_DRV, S_KER, S_EXT: begin
          if (chk_exp && !pulses_off) begin
            // Missing checkback at expiry: immediate internal stop.
            immediate_stop   <= 1'b1;
            int_pulse_cancel <= 1'b1;
            ev[`SPTS_EV_DRV_FAIL] <= (mode == 3'h1);
            ev[`SPTS_EV_KER_FAIL] <= (mode == 3'h2);
            ev[`SPTS_EV_EXT_FAIL] <= (mode == 3'h4);
            if (mode == 3'h4)
              alarm_info <= `SPTS_INFO_NO_CHECK;
            state            <= S_LOCK;
          end else if (chk_exp && !(mode == 3'h1 ? sel_drv : mode == 3'h2 ? sel_ker : sel_ext)) begin
            drv_pulse_cancel <= 1'b0;
            int_pulse_cancel <= 1'b0;
            ext_pulse_enable <= 1'b1;
            test_in_progress <= 1'b0;
            ext_test_running <= {AXES{1'b0}};
            ev[`SPTS_EV_PASS] <= 1'b1;
            state            <= S_IDLE;
          end
        end
        S_DONE: begin
          // Stop-F clears once every selection is released.
          if (!any_sel) begin
            stop_f <= 1'b0;
            state  <= S_IDLE;
          end
        end
        S_LOCK: begin
          // Only a power-on reset leaves this state.
          state <= S_LOCK;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Drive-channel status output mirrors the observed cancellation.
  always @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      drv_pulses_cancelled <= 1'b0;
      monitor_state        <= 4'h0;
    end else begin
      drv_pulses_cancelled <= pulses_off;
      monitor_state        <= monitor_state_in;
    end
  end

  // ---------------------------------------------------------------
  // Register writes and interrupt status
  // ---------------------------------------------------------------
  // A new event wins over a write-one-to-clear in the same cycle.
  always @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      ctrl        <= 3'h0;
      cfg         <= 2'h0;
      check_time  <= `SPTS_CHECK_RST;
      modesw_time <= `SPTS_MODESW_RST;
      irq_mask    <= 7'h00;
      irq_stat    <= 7'h00;
    end else begin
      irq_stat <= (irq_stat & ~((wr && avs_address == `SPTS_REG_IRQ_STAT) ?
                   avs_writedata[6:0] : 7'h00)) | ev;
      if (wr) begin
        case (avs_address)
          `SPTS_REG_CTRL:     ctrl        <= avs_writedata[2:0];
          `SPTS_REG_CFG:      cfg         <= avs_writedata[1:0];
          `SPTS_REG_CHECK:    check_time  <= avs_writedata[23:0];
          `SPTS_REG_MODESW:   modesw_time <= avs_writedata[23:0];
          `SPTS_REG_IRQ_MASK: irq_mask    <= avs_writedata[6:0];
          default:            ctrl        <= ctrl;
        endcase
      end
    end
  end

  // Read data is registered in the wait state, so it stands at the edge that completes the read.
  always @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      avs_readdata <= 32'h00000000;
      rd_done      <= 1'b0;
    end else if (avs_read && !rd_done) begin
      rd_done <= 1'b1;
      case (avs_address)
        `SPTS_REG_CTRL:     avs_readdata <= {29'h0, ctrl};
        `SPTS_REG_CFG:      avs_readdata <= {30'h0, cfg};
        `SPTS_REG_CHECK:    avs_readdata <= {8'h00, check_time};
        `SPTS_REG_MODESW:   avs_readdata <= {8'h00, modesw_time};
        `SPTS_REG_STATUS:   avs_readdata <= {20'h0, pulses_off, stop_f, immediate_stop, test_in_progress,
                                             2'h0, state};
        `SPTS_REG_IRQ_STAT: avs_readdata <= {25'h0, irq_stat};
        `SPTS_REG_IRQ_MASK: avs_readdata <= {25'h0, irq_mask};
        `SPTS_REG_ALARM:    avs_readdata <= {16'h0, alarm_info};
        default:            avs_readdata <= 32'h00000000;
      endcase
    end else begin
      rd_done <= 1'b0;
    end
  end
endmodule // spts_sequencer

// ---- tb/spts_drive_model.sv ----
// Purpose: Behavioural drive power stage that answers pulse cancel requests.
// Assumes: One axis group shares the cancel request and the status contacts.
// Notes:   The bench can make it slow, silent, stuck off or deaf on the I/O line.
`timescale 1ns/1ps
module spts_drive_model (
  input  wire  mclk,
  input  wire  cancel_req,
  input  wire  broken,
  input  wire  stuck,
  input  wire  io_dead,
  input  wire  slow,
  output logic status_io_in,
  output logic status_if_in
);
  integer cnt = 0;
  logic   off = 1'b0;
  // Unless stuck, the stage reports off only after it has reacted, so a slow stage tests the timer margin.
  always @(posedge mclk) begin
    cnt <= !cancel_req ? 0 : (cnt < 60 ? cnt + 1 : cnt);
    off <= stuck || (!broken && cancel_req && cnt >= (slow ? 40 : 3));
  end
  // A dead I/O contact reads as pulses on, so only the interface path carries the truth.
  assign status_io_in = off && !io_dead;
  assign status_if_in = off;
endmodule // spts_drive_model

// ---- tb/spts_sequencer_assertions.sv ----
// Purpose: Port-level checks of the shutdown path test sequencer.
// Assumes: Single clock domain on mclk with active-low reset.
// Notes:   Sees only top-level ports and is attached with bind.
`timescale 1ns/1ps
module spts_sequencer_assertions #(
  parameter AXES = 6
) (
  input wire            mclk,
  input wire            rst_n,
  input wire            avs_waitrequest,
  input wire            drv_test_select,
  input wire [AXES-1:0] axis_map,
  input wire [3:0]      monitor_state_in,
  input wire            drv_pulse_cancel,
  input wire            int_pulse_cancel,
  input wire            ext_pulse_enable,
  input wire            test_in_progress,
  input wire [AXES-1:0] ext_test_running,
  input wire            immediate_stop,
  input wire            stop_f,
  input wire [3:0]      monitor_state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Steady inputs give the pass-through time to settle through its register.
  sequence s_mon_steady;
    $stable(monitor_state_in) [*4];
  endsequence
  sequence s_stop_seen;
    immediate_stop ##1 1'b1;
  endsequence
  a_wait_one_cycle: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  a_lock_holds: assert property (s_stop_seen |-> immediate_stop && int_pulse_cancel)
    else $error("immediate stop left its lock");
  a_monitor_kept: assert property (s_mon_steady |-> monitor_state == monitor_state_in)
    else $error("monitor state altered");
  a_drv_cancel_hold: assert property ($fell(drv_pulse_cancel) |-> !$past(drv_test_select, 2))
    else $error("drive cancel dropped under selection");
  a_ext_map_only: assert property ((ext_test_running & ~axis_map) == '0)
    else $error("running alarm on unmapped axis");
  a_enable_drop_prog: assert property ($fell(ext_pulse_enable) |-> test_in_progress)
    else $error("enable dropped without test in progress");
  a_ext_run_enable: assert property (|ext_test_running && !immediate_stop |-> !ext_pulse_enable)
    else $error("external test with enable still up");
  a_stopf_no_test: assert property ($rose(stop_f) |-> !test_in_progress && ext_pulse_enable && !drv_pulse_cancel)
    else $error("test ran although pulses were off");
endmodule // spts_sequencer_assertions
bind spts_sequencer spts_sequencer_assertions #(.AXES(AXES)) i_spts_sequencer_assertions (.mclk, .rst_n,
  .avs_waitrequest, .drv_test_select, .axis_map, .monitor_state_in, .drv_pulse_cancel, .int_pulse_cancel,
  .ext_pulse_enable, .test_in_progress, .ext_test_running, .immediate_stop, .stop_f, .monitor_state);

// ---- tb/test_spts_sequencer.sv ----
// Purpose: Self-checking bench for the shutdown path test sequencer.
// Assumes: Check and mode-switch times are set to 5 us to keep the run short.
// Notes:   Every scenario starts from a power-on, since a failed test latches.
`timescale 1ns/1ps
`include "spts_defs.vh"
module test_spts_sequencer;
  logic        mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
  logic [3:0]  avs_address = 0, monitor_state_in = 0, monitor_state;
  logic [31:0] avs_writedata = 0, avs_readdata, d;
  logic        drv_test_select = 0, ker_test_select = 0, ext_test_select = 0, ext_stop_present = 0;
  logic [5:0]  axis_map = 0, ext_test_running;
  logic        status_io_in, status_if_in, drv_pulse_cancel, drv_pulses_cancelled, int_pulse_cancel;
  logic        ext_pulse_enable, test_in_progress, immediate_stop, stop_f;
  logic        broken = 0, stuck = 0, io_dead = 0, slow = 0;
  integer      fails = 0, check_count = 0;
  spts_sequencer #(.AXES(6)) i_spts_sequencer (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .drv_test_select, .ker_test_select, .ext_test_select,
    .axis_map, .status_io_in, .status_if_in, .ext_stop_present, .monitor_state_in, .drv_pulse_cancel,
    .drv_pulses_cancelled, .int_pulse_cancel, .ext_pulse_enable, .test_in_progress, .ext_test_running,
    .immediate_stop, .stop_f, .monitor_state, .irq);
  spts_drive_model i_spts_drive_model (.mclk, .cancel_req(drv_pulse_cancel | int_pulse_cancel | ~ext_pulse_enable),
    .broken, .stuck, .io_dead, .slow, .status_io_in, .status_if_in);
  // Free-running 20 MHz clock.
  always #25 mclk = ~mclk;
  task results; begin
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  end endtask
  task to; begin
    fails++;
    $display("[FAIL] %0t wait ran out", $time);
    results;
  end endtask
  task chk(input [31:0] g, input [31:0] e); begin
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  end endtask
  // Bus cycles hold the request until the edge that sees waitrequest low.
  task wr(input [3:0] a, input [31:0] v); integer n; begin
    @(posedge mclk) {avs_address, avs_writedata, avs_write} <= {a, v, 1'b1};
    n = 0;
    do begin @(posedge mclk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    avs_write <= 1'b0;
    if (n >= 20) to;
  end endtask
  task rd(input [3:0] a, output [31:0] v); integer n; begin
    @(posedge mclk) {avs_address, avs_read} <= {a, 1'b1};
    n = 0;
    do begin @(posedge mclk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    v = avs_readdata;
    avs_read <= 1'b0;
    if (n >= 20) to;
  end endtask
  // Waits until the chosen output reaches the level, within a bound.
  task ws(input integer s, input logic v, input integer lim); integer n; logic x; begin
    n = 0;
    do begin
      @(posedge mclk) #1 n++;
      case (s)
        0: x = drv_pulse_cancel;
        1: x = immediate_stop;
        2: x = ext_pulse_enable;
        3: x = stop_f;
        default: x = test_in_progress;
      endcase
    end while (x !== v && n < lim);
    if (x !== v) to;
  end endtask
  // Power-on with all selections low, so pulses are enabled before any test.
  task pon; begin
    @(posedge mclk) {rst_n, drv_test_select, ker_test_select, ext_test_select} <= 4'h0;
    {broken, stuck, io_dead, slow, ext_stop_present, monitor_state_in} <= 9'h000;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  end endtask
  task setup(input [31:0] cfg); begin
    wr(`SPTS_REG_CHECK, 32'h5);
    wr(`SPTS_REG_MODESW, 32'h5);
    wr(`SPTS_REG_CFG, cfg);
  end endtask
  task t_drv_pass; begin
    pon;
    rd(`SPTS_REG_CHECK, d);
    chk(d, `SPTS_CHECK_RST);
    setup(32'h0);
    @(posedge mclk) drv_test_select <= 1'b1;
    ws(0, 1, 10);
    repeat (250) @(posedge mclk);
    chk(drv_pulses_cancelled, 1);
    chk(drv_pulse_cancel, 1);
    chk(immediate_stop, 0);
    @(posedge mclk) drv_test_select <= 1'b0;
    ws(0, 0, 10);
    rd(`SPTS_REG_IRQ_STAT, d);
    chk(d[5:0], 6'h20);
    wr(`SPTS_REG_CTRL, 32'h1);
    ws(0, 1, 10);
    wr(`SPTS_REG_CTRL, 32'h0);
    chk(drv_pulse_cancel, 1);
    ws(0, 0, 200);
    $display("drive pass done");
  end endtask
  task t_drv_fail; begin
    pon;
    setup(32'h0);
    @(posedge mclk) {broken, drv_test_select} <= 2'h3;
    ws(1, 1, 200);
    chk(int_pulse_cancel, 1);
    rd(`SPTS_REG_IRQ_STAT, d);
    chk(d[0], 1);
    chk(irq, 0);
    wr(`SPTS_REG_IRQ_MASK, 32'h1);
    @(posedge mclk) #1 chk(irq, 1);
    wr(`SPTS_REG_IRQ_STAT, 32'h1);
    @(posedge mclk) #1 chk(irq, 0);
    rd(4'hC, d);
    chk(d, 0);
    $display("drive fail done");
  end endtask
  // Tests run one after another, each channel on its own.
  task t_ker_pass(input [31:0] cfg); begin
    pon;
    setup(cfg);
    @(posedge mclk) {io_dead, slow, ker_test_select} <= {~cfg[1], ~cfg[1], 1'b1};
    ws(4, 1, 10);
    chk(ext_pulse_enable, cfg[0]);
    repeat (250) @(posedge mclk);
    chk(int_pulse_cancel, cfg[0]);
    chk(immediate_stop, 0);
    @(posedge mclk) ker_test_select <= 1'b0;
    ws(4, 0, 20);
    chk(ext_pulse_enable, 1);
    $display("kernel pass done");
  end endtask
  task t_ext_fail; begin
    pon;
    setup(32'h2);
    @(posedge mclk) {axis_map, broken, ext_test_select} <= {6'h2D, 2'h3};
    ws(2, 0, 10);
    chk(ext_test_running, 6'h2D);
    ws(1, 1, 200);
    rd(`SPTS_REG_ALARM, d);
    chk(d[15:0], `SPTS_INFO_NO_CHECK);
    rd(`SPTS_REG_IRQ_STAT, d);
    chk(d[5:0], 6'h04);
    chk(int_pulse_cancel, 1);
    @(posedge mclk) ext_test_select <= 1'b0;
    repeat (100) @(posedge mclk);
    rd(`SPTS_REG_STATUS, d);
    chk({immediate_stop, d[5:0]}, 7'h60);
    $display("external fail done");
  end endtask
  task t_ext_stop; begin
    pon;
    setup(32'h2);
    @(posedge mclk) {axis_map, slow, ext_stop_present, monitor_state_in, ext_test_select} <= {6'h3, 2'h3, 4'hA, 1'b1};
    ws(2, 0, 10);
    repeat (250) @(posedge mclk);
    chk(monitor_state, 4'hA);
    rd(`SPTS_REG_ALARM, d);
    chk(d[15:0], `SPTS_INFO_EXT_STOP);
    rd(`SPTS_REG_IRQ_STAT, d);
    chk({immediate_stop, d[3]}, 2'h1);
    @(posedge mclk) ext_test_select <= 1'b0;
    ws(2, 1, 20);
    $display("external stop done");
  end endtask
  task t_stopf; begin
    pon;
    setup(32'h2);
    @(posedge mclk) stuck <= 1'b1;
    repeat (5) @(posedge mclk);
    ker_test_select <= 1'b1;
    ws(3, 1, 20);
    chk({test_in_progress, ext_pulse_enable}, 2'h1);
    rd(`SPTS_REG_IRQ_STAT, d);
    chk(d[4], 1);
    $display("stop f done");
  end endtask
  initial begin
    t_drv_pass;
    t_drv_fail;
    t_ker_pass(32'h2);
    t_ker_pass(32'h1);
    t_ext_fail;
    t_ext_stop;
    t_stopf;
    results;
  end
endmodule // test_spts_sequencer
